// *** rtl/pmc_delay.sv ***
// Purpose: down counter for a fixed wait
// Assumes: start is a one-cycle pulse
// Notes: done stays high until next start
`timescale 1ns/100ps
`include "pmc_params.svh"
module pmc_delay
#(
  parameter logic [`PMC_CNT_W-1:0] CYCLES = 8'h01
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  output logic done
);
  logic [`PMC_CNT_W-1:0] cnt_q;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      done <= 1'b1;
    end
    else if (start)
    begin
      cnt_q <= CYCLES;
      done <= 1'b0;
    end
    else if (cnt_q > 8'h01)
    begin
      cnt_q <= cnt_q - 8'h01;
    end
    else if (!done)
    begin
      cnt_q <= '0;
      done <= 1'b1;
    end
  end
endmodule

// *** rtl/pmc_params.svh ***
// Purpose: constants of the power mode clock manager
// Assumes: clk_sys at 25 MHz
// Notes: offsets are byte addresses on the apb bus
`ifndef PMC_PARAMS_SVH
`define PMC_PARAMS_SVH
`define PMC_CLK_MHZ 25
`define PMC_OFS_OSC_CTRL 12'h000
`define PMC_OFS_TMR1_CTRL 12'h004
`define PMC_OFS_STATE 12'h008
`define PMC_OFS_STRAP 12'h00C
`define PMC_BIT_IDLE 7
`define PMC_BIT_PRI_ACT 3
`define PMC_BIT_RC_STBL 2
`define PMC_BIT_SEC_ACT 6
`define PMC_BIT_SEC_EN 3
`define PMC_BIT_LF_SRC 7
`define PMC_CSD_NS 2000
`define PMC_CSD_CYC ((`PMC_CSD_NS * `PMC_CLK_MHZ + 999) / 1000)
`define PMC_SETTLE_NS 1000
`define PMC_SETTLE_CYC ((`PMC_SETTLE_NS * `PMC_CLK_MHZ + 999) / 1000)
`define PMC_SW_OLD_CYC 2
`define PMC_SW_NEW_CYC 4
`define PMC_CNT_W 8
`endif

// *** rtl/pmc_pkg.sv ***
// Purpose: types of the power mode clock manager
// Assumes: nothing
// Notes: none
package pmc_pkg;
  typedef enum logic [1:0]
  {
    PMC_SRC_PRI = 2'b00,
    PMC_SRC_SEC = 2'b01,
    PMC_SRC_RC = 2'b10
  } pmc_src_t;
  typedef enum logic [2:0]
  {
    PMC_ST_RUN = 3'b000,
    PMC_ST_SWITCH = 3'b001,
    PMC_ST_IDLE = 3'b010,
    PMC_ST_SLEEP = 3'b011,
    PMC_ST_WAKE = 3'b100
  } pmc_state_t;
  typedef struct packed
  {
    logic primary_ready;
    logic secondary_running;
    logic fast_rc_ready;
    logic wdt_enable;
    logic fscm_enable;
    logic two_speed_enable;
  } pmc_osc_in_t;
  typedef struct packed
  {
    logic primary_osc_on;
    logic secondary_osc_on;
    logic fast_rc_on;
    logic slow_rc_on;
    logic cpu_clk_en;
    logic periph_clk_en;
    pmc_src_t clk_sel;
  } pmc_clk_out_t;
endpackage

// *** rtl/pmc_sync.sv ***
// Purpose: three-stage synchroniser for one level
// Assumes: input from another clock domain
// Notes: change counts once stages two and three agree
`timescale 1ns/100ps
module pmc_sync
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q)
      begin
        q <= s3_q;
      end
    end
  end
endmodule

// *** rtl/pmc_top.sv ***
// Purpose: power mode clock manager with apb registers
// Assumes: oscillator status arrives asynchronously; sleep and wake from cpu logic on clk_sys
// Notes: clock gating is expressed as enables and selects for an external clock mux
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/100ps
`include "pmc_params.svh"
module pmc_top
  import pmc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_exec,
  input wire logic wake_irq,
  input wire logic wdt_timeout,
  input wire pmc_osc_in_t osc_in,
  output pmc_clk_out_t clk_out,
  output pmc_state_t mode_state
);
  ////////////////////////////////////////////////////////////////////////
  // synchronised oscillator status
  logic pri_rdy;
  logic secondary_run;
  logic rc_rdy;
  pmc_sync u_sync_pri
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .d(osc_in.primary_ready),
    .q(pri_rdy)
  );
  pmc_sync u_sync_sec
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .d(osc_in.secondary_running),
    .q(secondary_run)
  );
  pmc_sync u_sync_rc
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .d(osc_in.fast_rc_ready),
    .q(rc_rdy)
  );
  ////////////////////////////////////////////////////////////////////////
  // registers
  logic idle_on_sleep_q;
  logic clock_select_hi_q;
  logic clock_select_lo_q;
  logic [2:0] rc_freq_select_q;
  logic low_freq_source_select_q;
  logic secondary_osc_enable_q;
  logic primary_clock_active_q;
  logic fast_rc_stable_q;
  logic secondary_clock_active_q;
  logic wr_en;
  logic mapped;
  assign wr_en = psel & penable & pwrite;
  assign mapped = (paddr == `PMC_OFS_OSC_CTRL) || (paddr == `PMC_OFS_TMR1_CTRL)
    || (paddr == `PMC_OFS_STATE) || (paddr == `PMC_OFS_STRAP);
  // control bits change only by software; mode logic never writes them
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      idle_on_sleep_q <= 1'b0;
      clock_select_hi_q <= 1'b0;
      clock_select_lo_q <= 1'b0;
      rc_freq_select_q <= 3'h0;
      low_freq_source_select_q <= 1'b0;
      secondary_osc_enable_q <= 1'b0;
    end
    else if (wr_en && paddr == `PMC_OFS_OSC_CTRL)
    begin
      idle_on_sleep_q <= pwdata[`PMC_BIT_IDLE];
      rc_freq_select_q <= pwdata[6:4];
      clock_select_hi_q <= pwdata[1];
      clock_select_lo_q <= pwdata[0];
    end
    else if (wr_en && paddr == `PMC_OFS_TMR1_CTRL)
    begin
      low_freq_source_select_q <= pwdata[`PMC_BIT_LF_SRC];
      secondary_osc_enable_q <= pwdata[`PMC_BIT_SEC_EN];
    end
  end
  // apb answers in the access cycle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          `PMC_OFS_OSC_CTRL:
          begin
            prdata <= {24'h0000_00, idle_on_sleep_q, rc_freq_select_q, primary_clock_active_q,
              fast_rc_stable_q, clock_select_hi_q, clock_select_lo_q};
          end
          `PMC_OFS_TMR1_CTRL:
          begin
            prdata <= {24'h0000_00, low_freq_source_select_q, secondary_clock_active_q, 2'b00,
              secondary_osc_enable_q, 3'b000};
          end
          `PMC_OFS_STATE:
          begin
            prdata <= {27'h000_0000, mode_state, clk_out.clk_sel};
          end
          `PMC_OFS_STRAP:
          begin
            prdata <= {26'h000_0000, pri_rdy, secondary_run, rc_rdy, osc_in.wdt_enable,
              osc_in.fscm_enable, osc_in.two_speed_enable};
          end
          default:
          begin
            prdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // source decode
  pmc_src_t want_src;
  assign want_src = clock_select_hi_q ? PMC_SRC_RC : (clock_select_lo_q ? PMC_SRC_SEC : PMC_SRC_PRI);
  logic fast_req;
  assign fast_req = (rc_freq_select_q != 3'h0) | low_freq_source_select_q;
  ////////////////////////////////////////////////////////////////////////
  // delays
  logic csd_start;
  logic csd_done;
  logic sw_start;
  logic sw_done;
  logic settle_start;
  logic settle_done;
  logic fast_req_q;
  pmc_delay #(.CYCLES(8'(`PMC_CSD_CYC))) u_csd
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(csd_start),
    .done(csd_done)
  );
  pmc_delay #(.CYCLES(8'(`PMC_SW_OLD_CYC + `PMC_SW_NEW_CYC))) u_switch
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(sw_start),
    .done(sw_done)
  );
  pmc_delay #(.CYCLES(8'(`PMC_SETTLE_CYC))) u_settle
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(settle_start),
    .done(settle_done)
  );
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      fast_req_q <= 1'b0;
    end
    else
    begin
      fast_req_q <= fast_req;
    end
  end
  assign settle_start = fast_req & ~fast_req_q;
  ////////////////////////////////////////////////////////////////////////
  // mode state machine
  pmc_state_t state_q;
  pmc_src_t cur_src_q;
  logic wake;
  logic wake_pri_wait_q;
  assign wake = wake_irq | wdt_timeout;
  assign mode_state = state_q;
  assign sw_start = (state_q == PMC_ST_RUN) && (want_src != cur_src_q) && !sleep_exec;
  assign csd_start = (state_q == PMC_ST_IDLE || state_q == PMC_ST_SLEEP) && wake;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q <= PMC_ST_RUN;
      cur_src_q <= PMC_SRC_PRI;
      wake_pri_wait_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        PMC_ST_RUN:
        begin
          if (sleep_exec)
          begin
            if (!idle_on_sleep_q)
            begin
              state_q <= PMC_ST_SLEEP;
            end
            else if (want_src == PMC_SRC_SEC && !secondary_osc_enable_q)
            begin
              state_q <= PMC_ST_RUN;
            end
            else
            begin
              state_q <= PMC_ST_IDLE;
              cur_src_q <= want_src;
            end
          end
          else if (want_src != cur_src_q && !(want_src == PMC_SRC_SEC && !secondary_osc_enable_q))
          begin
            state_q <= PMC_ST_SWITCH;
          end
        end
        PMC_ST_SWITCH:
        begin
          // old source keeps clocking until the switch delay ends and, for a switch to the primary, until it is ready
          if (sw_done && (want_src != PMC_SRC_PRI || pri_rdy))
          begin
            cur_src_q <= want_src;
            state_q <= PMC_ST_RUN;
          end
        end
        PMC_ST_IDLE:
        begin
          if (wake)
          begin
            state_q <= PMC_ST_WAKE;
          end
        end
        PMC_ST_SLEEP:
        begin
          if (wake)
          begin
            state_q <= PMC_ST_WAKE;
            cur_src_q <= want_src;
            wake_pri_wait_q <= (want_src == PMC_SRC_PRI);
          end
        end
        PMC_ST_WAKE:
        begin
          if (wake_pri_wait_q && pri_rdy)
          begin
            wake_pri_wait_q <= 1'b0;
          end
          if (csd_done && (!wake_pri_wait_q || pri_rdy))
          begin
            state_q <= PMC_ST_RUN;
          end
        end
        default:
        begin
          state_q <= PMC_ST_RUN;
        end
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // clock status flags
  logic in_sleep;
  assign in_sleep = (state_q == PMC_ST_SLEEP);
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      primary_clock_active_q <= 1'b1;
      fast_rc_stable_q <= 1'b0;
      secondary_clock_active_q <= 1'b0;
    end
    else if (in_sleep)
    begin
      primary_clock_active_q <= 1'b0;
      fast_rc_stable_q <= 1'b0;
      secondary_clock_active_q <= 1'b0;
    end
    else if (state_q != PMC_ST_IDLE)
    begin
      primary_clock_active_q <= (cur_src_q == PMC_SRC_PRI) && pri_rdy;
      secondary_clock_active_q <= (cur_src_q == PMC_SRC_SEC);
      if (cur_src_q != PMC_SRC_RC || !fast_req)
      begin
        fast_rc_stable_q <= 1'b0;
      end
      else if (settle_done && rc_rdy && !settle_start)
      begin
        fast_rc_stable_q <= 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // clock enables and oscillator controls
  logic sw_to_pri;
  logic waking_pri;
  assign sw_to_pri = (state_q == PMC_ST_SWITCH) && (want_src == PMC_SRC_PRI);
  assign waking_pri = (state_q == PMC_ST_WAKE) && wake_pri_wait_q;
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      clk_out <= '{primary_osc_on: 1'b1, secondary_osc_on: 1'b0, fast_rc_on: 1'b0, slow_rc_on: 1'b1,
        cpu_clk_en: 1'b1, periph_clk_en: 1'b1, clk_sel: PMC_SRC_PRI};
    end
    else
    begin
      clk_out.primary_osc_on <= !in_sleep && (cur_src_q == PMC_SRC_PRI || sw_to_pri || waking_pri);
      clk_out.secondary_osc_on <= secondary_osc_enable_q;
      clk_out.fast_rc_on <= !in_sleep && fast_req;
      clk_out.slow_rc_on <= (!in_sleep && cur_src_q == PMC_SRC_RC && !fast_req)
        || osc_in.wdt_enable || osc_in.fscm_enable;
      clk_out.cpu_clk_en <= (state_q == PMC_ST_RUN || state_q == PMC_ST_SWITCH)
        || (state_q == PMC_ST_WAKE && csd_done && (!wake_pri_wait_q || pri_rdy));
      clk_out.periph_clk_en <= !in_sleep && !(waking_pri && !pri_rdy
        && !osc_in.two_speed_enable && !osc_in.fscm_enable)
        && !(cur_src_q == PMC_SRC_SEC && !secondary_run);
      clk_out.clk_sel <= (waking_pri && !pri_rdy && (osc_in.two_speed_enable || osc_in.fscm_enable))
        ? PMC_SRC_RC : cur_src_q;
    end
  end
endmodule

// *** tb/pmc_osc_model.sv ***
// Purpose: oscillator sources facing pmc_top
// Assumes: start-up times in clk_sys cycles
// Notes: sec_stall keeps the secondary dead
`timescale 1ns/100ps
module pmc_osc_model
  import pmc_pkg::*;
#(
  parameter int PRI_DLY = 20,
  parameter int SEC_DLY = 30,
  parameter int RC_DLY = 10
)
(
  input wire logic clk_sys,
  input wire pmc_clk_out_t clk_out,
  input wire logic sec_stall,
  output logic primary_ready,
  output logic secondary_running,
  output logic fast_rc_ready
);
  int pri_cnt = 0;
  int sec_cnt = 0;
  int rc_cnt = 0;
  //////////////////////////////////////////////////
  function automatic int step(input logic on, input int cnt, input int lim);
    return (on !== 1'b1) ? 0 : ((cnt < lim) ? cnt + 1 : cnt);
  endfunction
  // ready only after start-up, dropped at once when stopped
  always @(posedge clk_sys)
  begin
    pri_cnt <= step(clk_out.primary_osc_on, pri_cnt, PRI_DLY);
    sec_cnt <= step(clk_out.secondary_osc_on && !sec_stall, sec_cnt, SEC_DLY);
    rc_cnt <= step(clk_out.fast_rc_on, rc_cnt, RC_DLY);
  end
  assign primary_ready = (pri_cnt >= PRI_DLY);
  assign secondary_running = (sec_cnt >= SEC_DLY);
  assign fast_rc_ready = (rc_cnt >= RC_DLY);
endmodule

// *** tb/pmc_properties.sv ***
// Purpose: port checks of pmc_top
// Assumes: one clock domain, rst synchronous high
// Notes: bind at the foot
`timescale 1ns/100ps
module pmc_properties
  import pmc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sleep_exec,
  input wire logic wake_irq,
  input wire logic wdt_timeout,
  input wire pmc_osc_in_t osc_in,
  input wire pmc_clk_out_t clk_out,
  input wire pmc_state_t mode_state
);
  //////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////
  sequence s_idle_wake;
    (mode_state == PMC_ST_IDLE) ##1 (mode_state == PMC_ST_WAKE);
  endsequence
  sequence s_cpu_back;
    ##44 !clk_out.cpu_clk_en ##[1:10] clk_out.cpu_clk_en;
  endsequence
  AST_IDLE_WAKE_DELAY: assert property (s_idle_wake |-> s_cpu_back)
    else $error("cpu clock start delay wrong");
  AST_IDLE_CPU_OFF: assert property ($rose(mode_state == PMC_ST_IDLE) |=> !clk_out.cpu_clk_en)
    else $error("cpu clock on in idle");
  AST_PRIMARY_IDLE_ON: assert property ((mode_state == PMC_ST_IDLE) && (clk_out.clk_sel == PMC_SRC_PRI)
    |-> clk_out.primary_osc_on && clk_out.periph_clk_en)
    else $error("primary idle lost its clock");
  AST_SLEEP_OFF: assert property ((mode_state == PMC_ST_SLEEP) [*2]
    |-> !clk_out.cpu_clk_en && !clk_out.periph_clk_en)
    else $error("clocks running in sleep");
  AST_RC_PRI_OFF: assert property ($rose(clk_out.clk_sel == PMC_SRC_RC) |-> ##[0:2] !clk_out.primary_osc_on)
    else $error("primary kept on in internal run");
  AST_SLOW_RC_KEPT: assert property (osc_in.wdt_enable [*2] |-> clk_out.slow_rc_on)
    else $error("slow rc stopped with watchdog on");
  AST_SEC_HOLD: assert property (((mode_state == PMC_ST_IDLE) && (clk_out.clk_sel == PMC_SRC_SEC)
    && !osc_in.secondary_running) [*6] |-> !clk_out.periph_clk_en)
    else $error("peripheral clock before secondary runs");
  AST_APB_ZERO_WAIT: assert property (psel && !penable |=> pready)
    else $error("apb answer late");
  AST_UNMAPPED: assert property (pready && (paddr > 12'h00C) |-> pslverr)
    else $error("unmapped access not refused");
endmodule
bind pmc_top pmc_properties pmc_properties_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sleep_exec(sleep_exec), .wake_irq(wake_irq), .wdt_timeout(wdt_timeout), .osc_in(osc_in),
  .clk_out(clk_out), .mode_state(mode_state));

// *** tb/power_mode_clock_manager_tb_top.sv ***
// Purpose: self-checking bench of pmc_top
// Assumes: apb zero wait states
// Notes: register reads and port checks
`timescale 1ns/100ps
`include "pmc_params.svh"
`define CHK(n, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("Error %s expected %h seen %h", n, e, g); \
    end \
  end
module power_mode_clock_manager_tb_top
  import pmc_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sleep_exec = 1'b0;
  logic wake_irq = 1'b0;
  logic wdt_timeout = 1'b0;
  logic wdt_en = 1'b0;
  logic sec_stall = 1'b0;
  logic p_rdy;
  logic s_run;
  logic f_rdy;
  logic slv;
  logic [31:0] rd;
  pmc_osc_in_t osc_in;
  pmc_clk_out_t clk_out;
  pmc_state_t mode_state;
  int bad_count = 0;
  int compares = 0;
  assign osc_in = {p_rdy, s_run, f_rdy, wdt_en, 1'b0, 1'b0};
  //////////////////////////////////////////////////
  pmc_top pmc_top_inst (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_exec(sleep_exec), .wake_irq(wake_irq), .wdt_timeout(wdt_timeout), .osc_in(osc_in),
    .clk_out(clk_out), .mode_state(mode_state));
  pmc_osc_model pmc_osc_model_inst (.clk_sys(clk_sys), .clk_out(clk_out), .sec_stall(sec_stall),
    .primary_ready(p_rdy), .secondary_running(s_run), .fast_rc_ready(f_rdy));
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end
  //////////////////////////////////////////////////
  task automatic end_of_test;
    if (bad_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
    if (n >= 50)
    begin
      `CHK("apb", 1'b1, 1'b0)
      end_of_test();
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK("read", e, rd)
  endtask
  task automatic wait_for(input pmc_state_t m, input logic use_s, input pmc_src_t s);
    int n;
    n = 0;
    while ((mode_state !== m || (use_s && clk_out.clk_sel !== s)) && n < 500)
    begin
      @(posedge clk_sys);
      n++;
    end
    `CHK("mode", m, mode_state)
    if (n >= 500)
    begin
      `CHK("wait", 1'b0, 1'b1)
      end_of_test();
    end
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic slp;
    sleep_exec <= 1'b1;
    @(posedge clk_sys);
    sleep_exec <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wake(input logic by_wdt);
    wdt_timeout <= by_wdt;
    wake_irq <= !by_wdt;
    @(posedge clk_sys);
    wdt_timeout <= 1'b0;
    wake_irq <= 1'b0;
    @(posedge clk_sys);
  endtask
  //////////////////////////////////////////////////
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    `CHK("clk_out", 8'h9C, clk_out)
    repeat (30) @(posedge clk_sys);
    rchk(`PMC_OFS_OSC_CTRL, 32'h0000_0008);
    rchk(`PMC_OFS_TMR1_CTRL, 32'h0000_0000);
    rchk(12'h010, 32'h0000_0000);
    `CHK("slverr", 1'b1, slv)
    slp();
    wait_for(PMC_ST_SLEEP, 1'b0, PMC_SRC_PRI);
    `CHK("cpu_en", 1'b0, clk_out.cpu_clk_en)
    `CHK("pri_on", 1'b0, clk_out.primary_osc_on)
    rchk(`PMC_OFS_OSC_CTRL, 32'h0000_0000);
    wake(1'b0);
    wait_for(PMC_ST_RUN, 1'b1, PMC_SRC_PRI);
    `CHK("pri_rdy", 1'b1, p_rdy)
    rchk(`PMC_OFS_OSC_CTRL, 32'h0000_0008);
    apb(1'b1, `PMC_OFS_OSC_CTRL, 32'h0000_0080);
    slp();
    wait_for(PMC_ST_IDLE, 1'b1, PMC_SRC_PRI);
    `CHK("cpu_en", 1'b0, clk_out.cpu_clk_en)
    `CHK("periph_en", 1'b1, clk_out.periph_clk_en)
    rchk(`PMC_OFS_OSC_CTRL, 32'h0000_0088);
    wake(1'b1);
    repeat (40) @(posedge clk_sys);
    `CHK("cpu_en", 1'b0, clk_out.cpu_clk_en)
    wait_for(PMC_ST_RUN, 1'b1, PMC_SRC_PRI);
    rchk(`PMC_OFS_OSC_CTRL, 32'h0000_0088);
    apb(1'b1, `PMC_OFS_OSC_CTRL, 32'h0000_0003);
    wait_for(PMC_ST_RUN, 1'b1, PMC_SRC_RC);
    `CHK("pri_on", 1'b0, clk_out.primary_osc_on)
    `CHK("rc_on", 1'b0, clk_out.fast_rc_on)
    rchk(`PMC_OFS_OSC_CTRL, 32'h0000_0003);
    apb(1'b1, `PMC_OFS_OSC_CTRL, 32'h0000_0073);
    @(posedge clk_sys);
    `CHK("rc_on", 1'b1, clk_out.fast_rc_on)
    rchk(`PMC_OFS_OSC_CTRL, 32'h0000_0073);
    repeat (60) @(posedge clk_sys);
    rchk(`PMC_OFS_OSC_CTRL, 32'h0000_0077);
    apb(1'b1, `PMC_OFS_OSC_CTRL, 32'h0000_00F3);
    slp();
    wait_for(PMC_ST_IDLE, 1'b1, PMC_SRC_RC);
    rchk(`PMC_OFS_OSC_CTRL, 32'h0000_00F7);
    wake(1'b0);
    wait_for(PMC_ST_RUN, 1'b1, PMC_SRC_RC);
    rchk(`PMC_OFS_OSC_CTRL, 32'h0000_00F7);
    apb(1'b1, `PMC_OFS_OSC_CTRL, 32'h0000_00F0);
    repeat (2) @(posedge clk_sys);
    `CHK("sel", PMC_SRC_RC, clk_out.clk_sel)
    `CHK("cpu_en", 1'b1, clk_out.cpu_clk_en)
    wait_for(PMC_ST_RUN, 1'b1, PMC_SRC_PRI);
    rchk(`PMC_OFS_OSC_CTRL, 32'h0000_00F8);
    wdt_en <= 1'b1;
    apb(1'b1, `PMC_OFS_OSC_CTRL, 32'h0000_0081);
    slp();
    repeat (4) @(posedge clk_sys);
    `CHK("mode", PMC_ST_RUN, mode_state)
    `CHK("sel", PMC_SRC_PRI, clk_out.clk_sel)
    `CHK("slow_on", 1'b1, clk_out.slow_rc_on)
    apb(1'b1, `PMC_OFS_TMR1_CTRL, 32'h0000_0008);
    apb(1'b1, `PMC_OFS_OSC_CTRL, 32'h0000_0081);
    wait_for(PMC_ST_RUN, 1'b1, PMC_SRC_SEC);
    rchk(`PMC_OFS_TMR1_CTRL, 32'h0000_0048);
    rchk(`PMC_OFS_OSC_CTRL, 32'h0000_0081);
    sec_stall <= 1'b1;
    repeat (8) @(posedge clk_sys);
    slp();
    wait_for(PMC_ST_IDLE, 1'b1, PMC_SRC_SEC);
    repeat (6) @(posedge clk_sys);
    `CHK("periph_en", 1'b0, clk_out.periph_clk_en)
    sec_stall <= 1'b0;
    repeat (45) @(posedge clk_sys);
    `CHK("periph_en", 1'b1, clk_out.periph_clk_en)
    wake(1'b0);
    wait_for(PMC_ST_RUN, 1'b1, PMC_SRC_SEC);
    `CHK("sec_on", 1'b1, clk_out.secondary_osc_on)
    apb(1'b1, `PMC_OFS_OSC_CTRL, 32'h0000_0001);
    slp();
    wait_for(PMC_ST_SLEEP, 1'b0, PMC_SRC_SEC);
    `CHK("slow_on", 1'b1, clk_out.slow_rc_on)
    `CHK("sec_on", 1'b1, clk_out.secondary_osc_on)
    rchk(`PMC_OFS_TMR1_CTRL, 32'h0000_0008);
    wake(1'b1);
    wait_for(PMC_ST_RUN, 1'b1, PMC_SRC_SEC);
    rchk(`PMC_OFS_OSC_CTRL, 32'h0000_0001);
    end_of_test();
  end
endmodule
